// file: design/serial_port_ctrl_status_regs.sv
`timescale 1ns/1ps
`include "serial_port_regs_cfg.svh"
// Notes on behaviour
// - Bits 22:21 pick one, two or four lanes.
// - Bits 20:16 give wide frame length n+1.
// - Bits 15:12 give control frame length n+1.
// - Bits 9:8 pick the transfer kind.
// - Memory-read receives only after control data sent.
// - Bit 24 enables select toggling, resets clear.
// - Bit 7 clock polarity, bit 6 phase.
// - Bit 11 loopback test, bit 10 slave output.
// - Frame count holds sixteen bits, resets zero.
// - Microwire control holds kind, direction, handshake.
// - One select bit per slave, zero deselects.
// - Sixteen-bit divider sets serial clock rate.
// - Eight-bit transmit and receive thresholds, reset zero.
// - Read-only fifo levels, zero after reset.
// - Status register reports seven engine flags.
// - Raw status reports six interrupt sources.
// - Mask register, one bit per source.
// - Masked status reports active sources.
// - Clear registers clear event interrupts on read.
module serial_port_ctrl_status_regs (
   input  wire logic                                clk,
   input  wire logic                                rst,
   // Register port: one access per cycle, byte address, read data next cycle.
   input  wire logic                                reg_sel,
   input  wire logic                                reg_write,
   input  wire logic [7:0]                          reg_addr,
   input  wire logic [31:0]                         reg_wdata,
   output logic      [31:0]                         reg_rdata,
   // Configuration seen by the shift engine.
   output logic                                     port_enable,
   output serial_port_regs_pkg::lane_format_e       lane_format,
   output logic      [4:0]                          wide_data_frame_size,
   output logic      [3:0]                          control_frame_size,
   output serial_port_regs_pkg::transfer_kind_e     transfer_kind,
   output logic                                     rx_after_control,
   output logic                                     select_toggle_enable,
   output logic                                     clock_idle_polarity,
   output logic                                     clock_sample_phase,
   output logic                                     loopback_test,
   output logic                                     slave_output_enable,
   output logic      [1:0]                          protocol_format,
   output logic      [3:0]                          data_frame_size,
   output logic      [15:0]                         frame_count,
   output logic                                     microwire_transfer_kind,
   output logic                                     microwire_direction,
   output logic                                     microwire_handshake,
   output logic      [`NUM_SLAVES-1:0]              slave_select,
   output logic      [15:0]                         clock_divide_value,
   output logic      [7:0]                          tx_threshold_value,
   output logic      [7:0]                          rx_threshold_value,
   output logic                                     irq_out,
   // State reported by the engine and fifos.
   input  wire logic [7:0]                          tx_level_value,
   input  wire logic [7:0]                          rx_level_value,
   input  wire logic                                engine_busy,
   input  wire logic                                tx_not_full_flag,
   input  wire logic                                tx_empty_flag,
   input  wire logic                                rx_not_empty_flag,
   input  wire logic                                rx_full_flag,
   input  wire logic                                transmission_error_flag,
   input  wire logic                                collision_error_flag,
   input  wire logic                                tx_overflow_event,
   input  wire logic                                rx_underflow_event,
   input  wire logic                                rx_overflow_event,
   input  wire logic                                contention_event
);
   import serial_port_regs_pkg::*;

   // Stored register state.
   logic [31:0]            frame_control_q,  frame_control_d;   // Frame control word.
   logic [15:0]            frame_count_q,    frame_count_d;     // Frames per transfer.
   logic                   enable_q,         enable_d;          // Port enable.
   logic [2:0]             microwire_q,      microwire_d;       // Microwire controls.
   logic [`NUM_SLAVES-1:0] select_q,         select_d;          // Slave selects.
   logic [15:0]            divider_q,        divider_d;         // Clock divider.
   logic [7:0]             tx_thr_q,         tx_thr_d;          // Transmit threshold.
   logic [7:0]             rx_thr_q,         rx_thr_d;          // Receive threshold.
   irq_vec_t               mask_q,           mask_d;            // Interrupt mask.
   irq_vec_t               sticky_q,         sticky_d;          // Latched event sources.
   logic [31:0]            rdata_q,          rdata_d;           // Registered read data.
   irq_vec_t               raw_irq;                             // Raw source vector.
   irq_vec_t               masked_irq;                          // Sources after masking.
   irq_vec_t               clear_vec;                           // Clear-on-read request.
   logic                   wr;                                  // Write strobe.
   logic                   rd;                                  // Read strobe.

   assign wr = reg_sel & reg_write;
   assign rd = reg_sel & ~reg_write;

   // Raw view: level sources compare the fifo levels with the thresholds, event sources are sticky.
   always_comb begin
      raw_irq = sticky_q;
      raw_irq[`IRQ_TX_EMPTY] = tx_level_value <= tx_thr_q;
      raw_irq[`IRQ_RX_FULL]  = rx_level_value > rx_thr_q;
      masked_irq = raw_irq & mask_q;
   end

   // Decode which sticky events a read of a clear register wipes.
   always_comb begin
      clear_vec = `IRQ_RESET;
      if (rd) begin
         case (reg_addr)
            `OFS_TX_OVERFLOW_CLEAR:  clear_vec[`IRQ_TX_OVERFLOW]  = 1'b1;
            `OFS_RX_OVERFLOW_CLEAR:  clear_vec[`IRQ_RX_OVERFLOW]  = 1'b1;
            `OFS_RX_UNDERFLOW_CLEAR: clear_vec[`IRQ_RX_UNDERFLOW] = 1'b1;
            `OFS_CONTENTION_CLEAR:   clear_vec[`IRQ_CONTENTION]   = 1'b1;
            `OFS_ALL_CLEAR: begin
               clear_vec[`IRQ_TX_OVERFLOW]  = 1'b1;
               clear_vec[`IRQ_RX_OVERFLOW]  = 1'b1;
               clear_vec[`IRQ_RX_UNDERFLOW] = 1'b1;
               clear_vec[`IRQ_CONTENTION]   = 1'b1;
            end
            default: clear_vec = `IRQ_RESET;
         endcase
      end
   end

   // Next state of every register except the read data. A new event wins over a clear in the same cycle,
   // so a burst arriving while software clears is never lost.
   always_comb begin
      frame_control_d = frame_control_q;
      frame_count_d   = frame_count_q;
      enable_d        = enable_q;
      microwire_d     = microwire_q;
      select_d        = select_q;
      divider_d       = divider_q;
      tx_thr_d        = tx_thr_q;
      rx_thr_d        = rx_thr_q;
      mask_d          = mask_q;
      sticky_d        = sticky_q & ~clear_vec;
      sticky_d[`IRQ_TX_OVERFLOW]  = sticky_d[`IRQ_TX_OVERFLOW]  | tx_overflow_event;
      sticky_d[`IRQ_RX_UNDERFLOW] = sticky_d[`IRQ_RX_UNDERFLOW] | rx_underflow_event;
      sticky_d[`IRQ_RX_OVERFLOW]  = sticky_d[`IRQ_RX_OVERFLOW]  | rx_overflow_event;
      sticky_d[`IRQ_CONTENTION]   = sticky_d[`IRQ_CONTENTION]   | contention_event;
      // Level sources are not stored; keep their sticky slots at zero.
      sticky_d[`IRQ_TX_EMPTY] = 1'b0;
      sticky_d[`IRQ_RX_FULL]  = 1'b0;
      if (wr) begin
         case (reg_addr)
            // Only documented fields are kept, reserved bits stay zero.
            `OFS_FRAME_CONTROL:       frame_control_d = reg_wdata & 32'h01ff_ffff;
            `OFS_FRAME_COUNT_CONTROL: frame_count_d   = reg_wdata[15:0];
            `OFS_PORT_ENABLE:         enable_d        = reg_wdata[0];
            `OFS_MICROWIRE_CONTROL:   microwire_d     = reg_wdata[2:0];
            `OFS_SLAVE_SELECT:        select_d        = reg_wdata[`NUM_SLAVES-1:0];
            `OFS_CLOCK_DIVIDER:       divider_d       = reg_wdata[15:0];
            `OFS_TX_FIFO_THRESHOLD:   tx_thr_d        = reg_wdata[7:0];
            `OFS_RX_FIFO_THRESHOLD:   rx_thr_d        = reg_wdata[7:0];
            `OFS_INTERRUPT_MASK:      mask_d          = reg_wdata[5:0];
            default:                  mask_d          = mask_q;
         endcase
         // Bit 23 is reserved in the control word.
         frame_control_d[23] = 1'b0;
      end
   end

   // Read multiplexer; unmapped and write accesses return zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd) begin
         case (reg_addr)
            `OFS_FRAME_CONTROL:        rdata_d = frame_control_q;
            `OFS_FRAME_COUNT_CONTROL:  rdata_d = {16'h0000, frame_count_q};
            `OFS_PORT_ENABLE:          rdata_d = {31'h0, enable_q};
            `OFS_MICROWIRE_CONTROL:    rdata_d = {29'h0, microwire_q};
            `OFS_SLAVE_SELECT:         rdata_d = 32'(select_q);
            `OFS_CLOCK_DIVIDER:        rdata_d = {16'h0000, divider_q};
            `OFS_TX_FIFO_THRESHOLD:    rdata_d = {24'h0, tx_thr_q};
            `OFS_RX_FIFO_THRESHOLD:    rdata_d = {24'h0, rx_thr_q};
            `OFS_TX_FIFO_LEVEL:        rdata_d = {24'h0, tx_level_value};
            `OFS_RX_FIFO_LEVEL:        rdata_d = {24'h0, rx_level_value};
            `OFS_PORT_STATUS:          rdata_d = {25'h0, collision_error_flag,
                                                  transmission_error_flag, rx_full_flag,
                                                  rx_not_empty_flag, tx_empty_flag,
                                                  tx_not_full_flag, engine_busy};
            `OFS_INTERRUPT_MASK:       rdata_d = {26'h0, mask_q};
            `OFS_INTERRUPT_STATUS:     rdata_d = {26'h0, masked_irq};
            `OFS_RAW_INTERRUPT_STATUS: rdata_d = {26'h0, raw_irq};
            `OFS_TX_OVERFLOW_CLEAR:    rdata_d = {31'h0, masked_irq[`IRQ_TX_OVERFLOW]};
            `OFS_RX_OVERFLOW_CLEAR:    rdata_d = {31'h0, masked_irq[`IRQ_RX_OVERFLOW]};
            `OFS_RX_UNDERFLOW_CLEAR:   rdata_d = {31'h0, masked_irq[`IRQ_RX_UNDERFLOW]};
            `OFS_CONTENTION_CLEAR:     rdata_d = {31'h0, masked_irq[`IRQ_CONTENTION]};
            `OFS_ALL_CLEAR:            rdata_d = {31'h0, |masked_irq};
            default:                   rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Register stage; synchronous reset restores every field.
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_control_q <= `FRAME_CONTROL_RESET;
         frame_count_q   <= `HALF_RESET;
         enable_q        <= 1'b0;
         microwire_q     <= 3'h0;
         select_q        <= '0;
         divider_q       <= `HALF_RESET;
         tx_thr_q        <= `BYTE_RESET;
         rx_thr_q        <= `BYTE_RESET;
         mask_q          <= `IRQ_RESET;
         sticky_q        <= `IRQ_RESET;
         rdata_q         <= 32'h0000_0000;
      end else begin
         frame_control_q <= frame_control_d;
         frame_count_q   <= frame_count_d;
         enable_q        <= enable_d;
         microwire_q     <= microwire_d;
         select_q        <= select_d;
         divider_q       <= divider_d;
         tx_thr_q        <= tx_thr_d;
         rx_thr_q        <= rx_thr_d;
         mask_q          <= mask_d;
         sticky_q        <= sticky_d;
         rdata_q         <= rdata_d;
      end
   end

   // Field outputs toward the engine.
   assign reg_rdata            = rdata_q;
   assign port_enable          = enable_q;
   assign lane_format          =
      lane_format_e'(frame_control_q[`FC_LANE_FORMAT_HI:`FC_LANE_FORMAT_LO]);
   assign wide_data_frame_size = frame_control_q[`FC_WIDE_DFS_HI:`FC_WIDE_DFS_LO];
   assign control_frame_size   = frame_control_q[`FC_CTRL_FS_HI:`FC_CTRL_FS_LO];
   assign transfer_kind        = transfer_kind_e'(frame_control_q[`FC_KIND_HI:`FC_KIND_LO]);
   // Memory read holds receive off until the control frame is out; the engine obeys this.
   assign rx_after_control     = (transfer_kind == KIND_MEM_READ);
   assign select_toggle_enable = frame_control_q[`FC_SELECT_TOGGLE_BIT];
   assign clock_idle_polarity  = frame_control_q[`FC_IDLE_POL_BIT];
   assign clock_sample_phase   = frame_control_q[`FC_SAMPLE_PH_BIT];
   assign loopback_test        = frame_control_q[`FC_LOOPBACK_BIT];
   assign slave_output_enable  = frame_control_q[`FC_SLAVE_OE_BIT];
   assign protocol_format      = frame_control_q[`FC_PROTO_HI:`FC_PROTO_LO];
   assign data_frame_size      = frame_control_q[`FC_DFS_HI:`FC_DFS_LO];
   assign frame_count          = frame_count_q;
   assign microwire_transfer_kind = microwire_q[0];
   assign microwire_direction  = microwire_q[1];
   assign microwire_handshake  = microwire_q[2];
   assign slave_select         = select_q;
   assign clock_divide_value   = divider_q;
   assign tx_threshold_value   = tx_thr_q;
   assign rx_threshold_value   = rx_thr_q;
   assign irq_out              = |masked_irq;
endmodule : serial_port_ctrl_status_regs

// file: design/serial_port_regs_cfg.svh
`ifndef SERIAL_PORT_REGS_CFG_SVH
`define SERIAL_PORT_REGS_CFG_SVH
// Register byte offsets.
`define OFS_FRAME_CONTROL        8'h00
`define OFS_FRAME_COUNT_CONTROL  8'h04
`define OFS_PORT_ENABLE          8'h08
`define OFS_MICROWIRE_CONTROL    8'h0c
`define OFS_SLAVE_SELECT         8'h10
`define OFS_CLOCK_DIVIDER        8'h14
`define OFS_TX_FIFO_THRESHOLD    8'h18
`define OFS_RX_FIFO_THRESHOLD    8'h1c
`define OFS_TX_FIFO_LEVEL        8'h20
`define OFS_RX_FIFO_LEVEL        8'h24
`define OFS_PORT_STATUS          8'h28
`define OFS_INTERRUPT_MASK       8'h2c
`define OFS_INTERRUPT_STATUS     8'h30
`define OFS_RAW_INTERRUPT_STATUS 8'h34
`define OFS_TX_OVERFLOW_CLEAR    8'h38
`define OFS_RX_OVERFLOW_CLEAR    8'h3c
`define OFS_RX_UNDERFLOW_CLEAR   8'h40
`define OFS_CONTENTION_CLEAR     8'h44
`define OFS_ALL_CLEAR            8'h48
// Field positions in frame_control.
`define FC_SELECT_TOGGLE_BIT     24
`define FC_LANE_FORMAT_HI        22
`define FC_LANE_FORMAT_LO        21
`define FC_WIDE_DFS_HI           20
`define FC_WIDE_DFS_LO           16
`define FC_CTRL_FS_HI            15
`define FC_CTRL_FS_LO            12
`define FC_LOOPBACK_BIT          11
`define FC_SLAVE_OE_BIT          10
`define FC_KIND_HI               9
`define FC_KIND_LO               8
`define FC_IDLE_POL_BIT          7
`define FC_SAMPLE_PH_BIT         6
`define FC_PROTO_HI              5
`define FC_PROTO_LO              4
`define FC_DFS_HI                3
`define FC_DFS_LO                0
// Interrupt source bit positions.
`define IRQ_TX_EMPTY             0
`define IRQ_TX_OVERFLOW          1
`define IRQ_RX_UNDERFLOW         2
`define IRQ_RX_OVERFLOW          3
`define IRQ_RX_FULL              4
`define IRQ_CONTENTION           5
// Reset values and widths.
`define FRAME_CONTROL_RESET      32'h0000_0000
`define HALF_RESET               16'h0000
`define BYTE_RESET               8'h00
`define IRQ_RESET                6'h00
`define NUM_SLAVES               1
`endif

// file: design/serial_port_regs_pkg.sv
package serial_port_regs_pkg;
   // Lane format choices for the wide serial modes.
   typedef enum logic [1:0] {
      LANE_SINGLE = 2'h0,
      LANE_DUAL   = 2'h1,
      LANE_QUAD   = 2'h2,
      LANE_RSVD   = 2'h3
   } lane_format_e;
   // Transfer kinds.
   typedef enum logic [1:0] {
      KIND_TX_RX    = 2'h0,
      KIND_TX_ONLY  = 2'h1,
      KIND_RX_ONLY  = 2'h2,
      KIND_MEM_READ = 2'h3
   } transfer_kind_e;
   // Raw interrupt source vector.
   typedef logic [5:0] irq_vec_t;
endpackage : serial_port_regs_pkg

// file: tb/engine_side_model.sv
`timescale 1ns/1ps
// Stands in for the shift engine and fifos; flags always agree with the fill levels.
module engine_side_model #(
   parameter logic [7:0] DEPTH = 8'h10  // Fifo depth, a plain default.
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] tx_fill,
   input  wire logic [7:0] rx_fill,
   input  wire logic       busy_req,
   input  wire logic [1:0] err_req,
   input  wire logic [3:0] ev_req,
   output logic      [7:0] tx_lvl,
   output logic      [7:0] rx_lvl,
   output logic      [6:0] flags,
   output logic      [3:0] ev
);
   logic [3:0] ev_q;  // Last request, so a held request still gives one pulse.
   // Event requests become single-cycle pulses.
   always_ff @(posedge clk) begin
      ev_q <= ev_req;
   end
   // Fifos read empty while in reset, as the real ones do.
   always_comb begin
      tx_lvl = rst ? 8'h00 : tx_fill;
      rx_lvl = rst ? 8'h00 : rx_fill;
      flags  = {err_req, rx_lvl == DEPTH, rx_lvl != 8'h00, tx_lvl == 8'h00, tx_lvl < DEPTH,
                busy_req};
      ev     = ev_req & ~ev_q;
   end
endmodule : engine_side_model

// file: tb/serial_port_ctrl_status_regs_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the control and status register bank.
module serial_port_ctrl_status_regs_bench;
   import serial_port_regs_pkg::*;
   logic clk, rst, reg_sel, reg_write, busy_req, rx_after_control, irq_out, port_en;
   logic [7:0] reg_addr, tx_fill, rx_fill, tx_lvl, rx_lvl;
   logic [31:0] reg_wdata, reg_rdata;
   logic [1:0] err_req;
   logic [3:0] ev_req, ev;
   logic [6:0] flags;
   logic [15:0] frame_count;
   logic [0:0] slave_select;
   wire [30:0] cfg;  // Configuration outputs gathered for one compare.
   lane_format_e lane_format;
   transfer_kind_e transfer_kind;
   int num_errors, cmp_count, cycles;
   engine_side_model u_eng (.clk(clk), .rst(rst), .tx_fill(tx_fill), .rx_fill(rx_fill),
      .busy_req(busy_req), .err_req(err_req), .ev_req(ev_req), .tx_lvl(tx_lvl), .rx_lvl(rx_lvl),
      .flags(flags), .ev(ev));
   serial_port_ctrl_status_regs dut (.clk(clk), .rst(rst), .reg_sel(reg_sel),
      .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .port_enable(port_en), .lane_format(lane_format), .wide_data_frame_size(cfg[4:0]),
      .control_frame_size(cfg[8:5]), .transfer_kind(transfer_kind),
      .rx_after_control(rx_after_control), .select_toggle_enable(cfg[29]),
      .clock_idle_polarity(cfg[30]), .clock_sample_phase(cfg[9]), .loopback_test(cfg[10]),
      .slave_output_enable(cfg[11]), .protocol_format(cfg[13:12]), .data_frame_size(cfg[17:14]),
      .frame_count(frame_count), .microwire_transfer_kind(cfg[18]),
      .microwire_direction(cfg[19]), .microwire_handshake(cfg[20]),
      .slave_select(slave_select), .clock_divide_value(), .tx_threshold_value(),
      .rx_threshold_value(cfg[28:21]), .irq_out(irq_out), .tx_level_value(tx_lvl),
      .rx_level_value(rx_lvl), .engine_busy(flags[0]), .tx_not_full_flag(flags[1]),
      .tx_empty_flag(flags[2]), .rx_not_empty_flag(flags[3]), .rx_full_flag(flags[4]),
      .transmission_error_flag(flags[5]), .collision_error_flag(flags[6]),
      .tx_overflow_event(ev[0]), .rx_underflow_event(ev[1]), .rx_overflow_event(ev[2]),
      .contention_event(ev[3]));
   task automatic end_of_test;
      if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Accesses start at a falling edge and leave the select up for a following access.
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      reg_sel = 1'b1;
      reg_write = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
   endtask : reg_wr
   // Read data is registered at the taking edge, so it is judged at the next fall.
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      reg_sel = 1'b1;
      reg_write = 1'b0;
      reg_addr = a;
      @(negedge clk);
      check(reg_rdata, exp);
   endtask : reg_rd
   task automatic idle;
      reg_sel = 1'b0;
      @(negedge clk);
   endtask : idle
   // Every register after reset, plus one unmapped place past the clear registers.
   task automatic t_reset;
      logic [31:0] e;  // Expected word for this place.
      for (int a = 0; a <= 8'h4c; a += 4) begin
         e = a == 8'h28 ? 32'h06 : a == 8'h34 ? 32'h01 : 32'h0;
         reg_rd(8'(a), e);
      end
      check(cfg, 32'h0);
   endtask : t_reset
   // All ones into each writable register and the transmit level: only the documented bits stick, read-only stays put.
   task automatic t_fields;
      logic [7:0] fa [10];
      logic [31:0] fm [10];
      fa = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h2c, 8'h20};
      fm = '{32'h017f_ffff, 32'hffff, 32'h1, 32'h7, 32'h1, 32'hffff, 32'hff, 32'hff, 32'h3f, 0};
      for (int i = 0; i < 10; i++) begin
         reg_wr(fa[i], 32'hffff_ffff);
         reg_rd(fa[i], fm[i]);
      end
      check({frame_count, slave_select, port_en}, {16'hffff, 1'b1, 1'b1});
      check(cfg, 32'h7fff_ffff);
   endtask : t_fields
   // Each transfer kind; the one-way kinds only with a wide lane format.
   task automatic t_kinds;
      logic [1:0] ln;
      logic [31:0] d;
      for (int i = 0; i < 4; i++) begin
         ln = i == 1 ? 2'h1 : i == 2 ? 2'h2 : 2'h0;
         d = {9'h0, ln, 11'h0, 2'(i), 8'h0};
         reg_wr(8'h00, d);
         reg_rd(8'h00, d);
         check({lane_format, transfer_kind, rx_after_control},
               {ln, 2'(i), i == 3});
      end
   endtask : t_kinds
   // Sticky sources, masking, clear on read, and the status flags.
   task automatic t_irq;
      tx_fill = 8'h05;
      rx_fill = 8'h04;
      busy_req = 1'b1;
      err_req = 2'h3;
      ev_req = 4'hf;
      reg_wr(8'h18, 32'h2);
      reg_wr(8'h1c, 32'h3);
      ev_req = 4'h0;
      reg_wr(8'h2c, 32'h2);
      reg_rd(8'h34, 32'h3e);
      reg_rd(8'h30, 32'h02);
      check(irq_out, 1'b1);
      reg_rd(8'h38, 32'h1);
      reg_rd(8'h34, 32'h3c);
      reg_rd(8'h3c, 32'h0);
      reg_rd(8'h34, 32'h34);
      reg_rd(8'h48, 32'h0);
      reg_rd(8'h34, 32'h10);
      // An overflow that lands with the clearing read must survive it.
      ev_req = 4'h1;
      reg_rd(8'h38, 32'h0);
      ev_req = 4'h0;
      reg_rd(8'h34, 32'h12);
      reg_wr(8'h2c, 32'h10);
      reg_rd(8'h30, 32'h10);
      reg_rd(8'h28, 32'h6b);
      reg_rd(8'h20, 32'h5);
      reg_rd(8'h24, 32'h4);
      reg_wr(8'h2c, 32'h0);
      idle();
      check(irq_out, 1'b0);
   endtask : t_irq
   // A second reset in mid-run clears fields and sticky sources.
   task automatic t_rerst;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      reg_rd(8'h00, 32'h0);
      reg_rd(8'h34, 32'h10);
      check(frame_count, 16'h0);
   endtask : t_rerst
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // A hang is cut short well past the length of the whole sequence.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      {rst, reg_sel, reg_write, reg_addr, reg_wdata} = {1'b1, 42'h0};
      {tx_fill, rx_fill, busy_req, err_req, ev_req} = 23'h0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_fields();
      t_kinds();
      t_irq();
      t_rerst();
      end_of_test();
   end
endmodule : serial_port_ctrl_status_regs_bench

// file: tb/serial_port_regs_asserts.sv
`timescale 1ns/1ps
// Watches the register port and seven of the configuration outputs of the bank.
module serial_port_regs_asserts (
   input wire logic                                 clk,
   input wire logic                                 rst,
   input wire logic                                 reg_sel,
   input wire logic                                 reg_write,
   input wire logic [7:0]                           reg_addr,
   input wire logic [31:0]                          reg_wdata,
   input wire logic [31:0]                          reg_rdata,
   input wire serial_port_regs_pkg::transfer_kind_e transfer_kind,
   input wire logic                                 rx_after_control,
   input wire logic                                 select_toggle_enable,
   input wire logic                                 clock_idle_polarity,
   input wire logic [15:0]                          frame_count,
   input wire logic [15:0]                          clock_divide_value,
   input wire logic [7:0]                           tx_threshold_value,
   input wire logic [7:0]                           tx_level_value
);
   import serial_port_regs_pkg::*;
   // One clock domain, so one default clock and one reset cover all checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic wr = reg_sel && reg_write;   // A write is taken this cycle.
   wire logic rd = reg_sel && !reg_write;  // A read is taken this cycle.
   // The memory-read flag is judged against the written kind bits, not the kind output.
   mem_read_flag_a: assert property (wr && reg_addr == 8'h00 |=>
      rx_after_control == ($past(reg_wdata[9:8]) == 2'h3))
      else $error("memory read flag does not follow the kind");
   kind_write_a: assert property (wr && reg_addr == 8'h00 |=>
      transfer_kind == $past(reg_wdata[9:8]))
      else $error("transfer kind not taken from write");
   pol_toggle_a: assert property (wr && reg_addr == 8'h00 |=>
      select_toggle_enable == $past(reg_wdata[24]) && clock_idle_polarity == $past(reg_wdata[7]))
      else $error("toggle or polarity bit not taken");
   count_write_a: assert property (wr && reg_addr == 8'h04 |=>
      frame_count == $past(reg_wdata[15:0]))
      else $error("frame count not taken from write");
   divider_write_a: assert property (wr && reg_addr == 8'h14 |=>
      clock_divide_value == $past(reg_wdata[15:0]))
      else $error("divider not taken from write");
   thresh_write_a: assert property (wr && reg_addr == 8'h18 |=>
      tx_threshold_value == $past(reg_wdata[7:0]))
      else $error("transmit threshold not taken");
   level_read_a: assert property (rd && reg_addr == 8'h20 |=>
      reg_rdata == {24'h0, $past(tx_level_value)})
      else $error("transmit level read wrong");
   idle_rdata_a: assert property (!rd |=> reg_rdata == 32'h0)
      else $error("read data not zero without a read");
   keep_config_a: assert property (!wr |=>
      $stable(frame_count) && $stable(clock_divide_value))
      else $error("configuration changed without a write");
   reset_clear_a: assert property ($fell(rst) |-> frame_count == 16'h0 &&
      transfer_kind == KIND_TX_RX && reg_rdata == 32'h0)
      else $error("fields not cleared by reset");
endmodule : serial_port_regs_asserts

bind serial_port_ctrl_status_regs serial_port_regs_asserts u_chk (.clk(clk), .rst(rst),
   .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .transfer_kind(transfer_kind), .rx_after_control(rx_after_control),
   .select_toggle_enable(select_toggle_enable), .clock_idle_polarity(clock_idle_polarity),
   .frame_count(frame_count), .clock_divide_value(clock_divide_value),
   .tx_threshold_value(tx_threshold_value), .tx_level_value(tx_level_value));
